/* verilog/crip_pkg.sv */
// Constants and carriers for the CAN receive-edit, interrupt and power control block.
// Assumes a 32-bit APB master and a bit engine in the same clock domain.
package crip_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CRIP_EDIT_OFS  = 8'h00;
  localparam logic [7:0] CRIP_CTRL_OFS  = 8'h04;
  localparam logic [7:0] CRIP_ESTAT_OFS = 8'h08;
  localparam logic [7:0] CRIP_IRQ_OFS   = 8'h0c;
  localparam logic [7:0] CRIP_TX_OFS    = 8'h10;
  localparam logic [7:0] CRIP_FRESH_OFS = 8'h14;
  localparam logic [7:0] CRIP_ALLOW_OFS = 8'h18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CRIP_PERMIT_BIT = 7;
  localparam int CRIP_INIT_BIT   = 0;
  localparam int CRIP_LP_BIT     = 1;
  localparam int CRIP_STOPSEL_BIT = 2;
  localparam int CRIP_WAKE_BIT   = 0;
  localparam int CRIP_OVR_BIT    = 1;
  localparam int CRIP_GRANT_BIT  = 2;
  localparam int CRIP_IRQ_ERR    = 0;
  localparam int CRIP_IRQ_RX     = 1;
  localparam int CRIP_IRQ_TX0    = 2;
  localparam int CRIP_IRQ_TX1    = 3;
  localparam int CRIP_TXP_LSB    = 0;
  localparam int CRIP_TXC_LSB    = 4;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  CRIP_EDIT_RST  = 8'h00;
  localparam logic [2:0]  CRIP_CTRL_RST  = 3'h0;
  localparam logic [15:0] CRIP_ALLOW_RST = 16'h0000;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CRIP_LP_RUN, CRIP_LP_SLEEP, CRIP_LP_STOP
  } crip_lp_t;
  typedef struct packed {
    logic       frame_valid;
    logic       hit;
    logic       masked;
    logic       store_start;
    logic       store_done;
    logic [3:0] idx;
  } crip_rx_t;
  typedef struct packed {
    logic bus_off;
    logic tx_lvl;
    logic rx_lvl;
  } crip_lvl_t;
endpackage : crip_pkg

/* verilog/crip_ctl.sv */
// Receive-buffer edit lock, interrupt flags and low-power control of a CAN controller.
// Assumes a 32-bit APB master and a bit engine on i_clk driving receive, transmit and wake events.
//
// Functional notes
// - Permit set excludes selected buffer from matching
// - Ongoing store into selected buffer completes first
// - Fresh flag set on store start or done
// - Masked-buffer store also writes received identifier
// - Four flags: error, receive, transmit 0, 1
// - Transmit flag on pending bit falling edge
// - Only device clears pending; software requests cancel
// - Receive flag needs valid, hit, stored, allowed
// - Receive flag no later than next frame's bit7
// - Error flag on level change, overrun, wake
// - Wake flag set blocks further error events
// - Clock return puts device into overrun
// - Sleep request reports grant or refusal via wake
// - Sleep left on bus activity, then resynchronise
// - Stop request uses the sleep handshake
// - Stop ignores bus; software clears request
// - Four-bit index selects buffer zero to fifteen
// - Init request clears permit bit
module crip_ctl
  import crip_pkg::*;
#(
  parameter int NBUF = 16
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Bit engine events
  input  wire crip_rx_t          i_rx,
  input  wire crip_lvl_t         i_lvl,
  input  wire logic              i_ovr,
  input  wire logic [1:0]        i_tx_done,
  input  wire logic [1:0]        i_tx_aborted,
  input  wire logic              i_clk_resume,
  input  wire logic              i_bus_busy,
  input  wire logic              i_bus_wake,
  // Controls to the bit engine
  output logic      [NBUF-1:0]   o_buf_exclude,
  output logic                   o_id_write,
  output logic      [1:0]        o_tx_pending,
  output logic      [1:0]        o_tx_cancel_req,
  output logic                   o_init,
  output logic                   o_resync,
  output crip_lp_t               o_lp_state,
  output logic      [3:0]        o_irq_flags
);
  // ****************************************
  // Parameter check
  // ****************************************
  if (NBUF != 16) begin : g_chk
    $error("crip_ctl serves sixteen receive buffers only");
  end

  function automatic logic [NBUF-1:0] onehot(input logic [3:0] idx);
    onehot = '0;
    onehot[idx] = 1'b1;
  endfunction : onehot

  // ****************************************
  // APB decode
  // ****************************************
  logic           wr;
  logic           rd;
  logic           hit_reg_any;
  logic [31:0]    rdata;
  logic [7:0]     edit_reg;
  logic [2:0]     ctrl_reg;
  logic           wake_reg;
  logic           ovr_reg;
  logic           grant_reg;
  logic [3:0]     irq_reg;
  logic [1:0]     txp_reg;
  logic [1:0]     txc_reg;
  logic [NBUF-1:0] fresh_reg;
  logic [NBUF-1:0] allow_reg;
  crip_lp_t       lp_reg;

  // Access completes on the second access-phase edge
  assign wr = i_psel && i_penable && o_pready && i_pwrite;
  assign rd = i_psel && i_penable && !o_pready && !i_pwrite;

  always_comb begin
    rdata = 32'h0000_0000;
    hit_reg_any = 1'b1;
    if (i_paddr == CRIP_EDIT_OFS) begin
      rdata[7:0] = edit_reg;
    end else if (i_paddr == CRIP_CTRL_OFS) begin
      rdata[2:0] = ctrl_reg;
    end else if (i_paddr == CRIP_ESTAT_OFS) begin
      rdata[CRIP_WAKE_BIT]  = wake_reg;
      rdata[CRIP_OVR_BIT]   = ovr_reg;
      rdata[CRIP_GRANT_BIT] = grant_reg;
      rdata[6:4] = i_lvl;
    end else if (i_paddr == CRIP_IRQ_OFS) begin
      rdata[3:0] = irq_reg;
    end else if (i_paddr == CRIP_TX_OFS) begin
      rdata[CRIP_TXP_LSB+:2] = txp_reg;
      rdata[CRIP_TXC_LSB+:2] = txc_reg;
    end else if (i_paddr == CRIP_FRESH_OFS) begin
      rdata[NBUF-1:0] = fresh_reg;
    end else if (i_paddr == CRIP_ALLOW_OFS) begin
      rdata[NBUF-1:0] = allow_reg;
    end else begin
      hit_reg_any = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && !hit_reg_any;
      o_prdata  <= rd ? rdata : 32'h0000_0000;
    end
  end

  function automatic logic wsel(input logic [7:0] ofs);
    wsel = wr && (i_paddr == ofs);
  endfunction : wsel

  // ****************************************
  // Buffer edit lock
  // ****************************************
  logic           storing_reg;
  logic [3:0]     store_idx_reg;
  logic [NBUF-1:0] excl_next;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      edit_reg <= CRIP_EDIT_RST;
    end else if (ctrl_reg[CRIP_INIT_BIT]) begin
      edit_reg[CRIP_PERMIT_BIT] <= 1'b0;
    end else if (wsel(CRIP_EDIT_OFS)) begin
      // Upper bits other than permit read zero
      edit_reg <= {i_pwdata[CRIP_PERMIT_BIT], 3'h0, i_pwdata[3:0]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      storing_reg   <= 1'b0;
      store_idx_reg <= 4'h0;
    end else if (i_rx.store_start) begin
      storing_reg   <= 1'b1;
      store_idx_reg <= i_rx.idx;
    end else if (i_rx.store_done) begin
      storing_reg   <= 1'b0;
    end
  end

  // Lock is withheld while the same buffer is being stored
  always_comb begin
    excl_next = '0;
    if (edit_reg[CRIP_PERMIT_BIT]) begin
      excl_next = onehot(edit_reg[3:0]);
    end
    if (storing_reg && store_idx_reg == edit_reg[3:0]) begin
      excl_next = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_buf_exclude <= '0;
    end else begin
      o_buf_exclude <= excl_next;
    end
  end

  // ****************************************
  // Receive bookkeeping
  // ****************************************
  logic [NBUF-1:0] fresh_set;
  logic            rx_ok;

  assign fresh_set = (i_rx.store_start || i_rx.store_done) ? onehot(i_rx.idx) : '0;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fresh_reg <= '0;
    end else begin
      // Set beats a simultaneous clear
      fresh_reg <= (fresh_reg & ~(wsel(CRIP_FRESH_OFS) ? i_pwdata[NBUF-1:0] : '0))
                   | fresh_set;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      allow_reg <= CRIP_ALLOW_RST;
    end else if (wsel(CRIP_ALLOW_OFS)) begin
      allow_reg <= i_pwdata[NBUF-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_id_write <= 1'b0;
    end else begin
      o_id_write <= i_rx.store_done && i_rx.masked;
    end
  end

  // Raised one edge after the store completes, well inside the next frame
  assign rx_ok = i_rx.frame_valid && i_rx.hit && i_rx.store_done
                 && allow_reg[i_rx.idx];

  // ****************************************
  // Transmit pending and cancel
  // ****************************************
  logic [1:0] txp_clr;

  assign txp_clr = txp_reg & (i_tx_done | (i_tx_aborted & txc_reg));

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      txp_reg <= 2'b00;
      txc_reg <= 2'b00;
    end else begin
      // Software can set pending and cancel, never clear them
      txp_reg <= (txp_reg & ~txp_clr)
                 | (wsel(CRIP_TX_OFS) ? i_pwdata[CRIP_TXP_LSB+:2] : 2'b00);
      txc_reg <= (txc_reg & ~txp_clr & txp_reg)
                 | (wsel(CRIP_TX_OFS) ? i_pwdata[CRIP_TXC_LSB+:2] & txp_reg : 2'b00);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_tx_pending    <= 2'b00;
      o_tx_cancel_req <= 2'b00;
    end else begin
      o_tx_pending    <= txp_reg;
      o_tx_cancel_req <= txc_reg;
    end
  end

  // ****************************************
  // Control and low-power modes
  // ****************************************
  logic wake_set;
  logic lp_leave;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_reg <= CRIP_CTRL_RST;
    end else if (wsel(CRIP_CTRL_OFS)) begin
      ctrl_reg <= i_pwdata[2:0];
    end else if (lp_leave || (lp_reg == CRIP_LP_RUN && ctrl_reg[CRIP_LP_BIT] && i_bus_busy)) begin
      // Granted request keeps the bit, else sleep would end at once
      ctrl_reg[CRIP_LP_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      lp_reg    <= CRIP_LP_RUN;
      grant_reg <= 1'b0;
    end else begin
      case (lp_reg)
        CRIP_LP_RUN: begin
          if (ctrl_reg[CRIP_LP_BIT]) begin
            grant_reg <= !i_bus_busy;
            if (!i_bus_busy) begin
              lp_reg <= ctrl_reg[CRIP_STOPSEL_BIT] ? CRIP_LP_STOP : CRIP_LP_SLEEP;
            end
          end
        end
        CRIP_LP_SLEEP: begin
          if (i_bus_wake || !ctrl_reg[CRIP_LP_BIT]) begin
            lp_reg    <= CRIP_LP_RUN;
            grant_reg <= 1'b0;
          end
        end
        CRIP_LP_STOP: begin
          if (!ctrl_reg[CRIP_LP_BIT]) begin
            lp_reg    <= CRIP_LP_RUN;
            grant_reg <= 1'b0;
          end
        end
        default: lp_reg <= CRIP_LP_RUN;
      endcase
    end
  end

  // Stop ignores bus wake; only sleep is left on bus activity
  assign lp_leave = lp_reg == CRIP_LP_SLEEP && i_bus_wake;
  assign wake_set = (lp_reg == CRIP_LP_RUN && ctrl_reg[CRIP_LP_BIT]) || lp_leave;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_resync   <= 1'b0;
      o_init     <= 1'b0;
      o_lp_state <= CRIP_LP_RUN;
    end else begin
      o_resync   <= lp_leave;
      o_init     <= ctrl_reg[CRIP_INIT_BIT];
      o_lp_state <= lp_reg;
    end
  end

  // ****************************************
  // Error status
  // ****************************************
  crip_lvl_t lvl_prev_reg;
  logic      ovr_prev_reg;
  logic      ovr_rise;
  logic      wake_rise;
  logic      err_ev;

  // Follows the pins through reset, so a level held across release is no event
  always_ff @(posedge i_clk) begin
    lvl_prev_reg <= i_lvl;
    ovr_prev_reg <= i_ovr;
  end

  // A resumed clock marks overrun as well
  assign ovr_rise = (i_ovr && !ovr_prev_reg) || i_clk_resume;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wake_reg <= 1'b0;
      ovr_reg  <= 1'b0;
    end else begin
      wake_reg <= (wake_reg && !(wsel(CRIP_ESTAT_OFS) && i_pwdata[CRIP_WAKE_BIT]))
                  || wake_set;
      ovr_reg  <= (ovr_reg && !(wsel(CRIP_ESTAT_OFS) && i_pwdata[CRIP_OVR_BIT]))
                  || ovr_rise;
    end
  end

  assign wake_rise = wake_set && !wake_reg;
  // Wake still set hides every other error cause
  assign err_ev = wake_rise
                  || (!wake_reg && ((i_lvl != lvl_prev_reg) || ovr_rise));

  // ****************************************
  // Interrupt flags
  // ****************************************
  logic [3:0] irq_set;

  always_comb begin
    irq_set = 4'h0;
    irq_set[CRIP_IRQ_ERR] = err_ev;
    irq_set[CRIP_IRQ_RX]  = rx_ok;
    irq_set[CRIP_IRQ_TX0] = txp_clr[0];
    irq_set[CRIP_IRQ_TX1] = txp_clr[1];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      irq_reg <= 4'h0;
    end else begin
      irq_reg <= (irq_reg & ~(wsel(CRIP_IRQ_OFS) ? i_pwdata[3:0] : 4'h0))
                 | irq_set;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_irq_flags <= 4'h0;
    end else begin
      o_irq_flags <= irq_reg;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_EXCL: assert property (@(posedge i_clk) disable iff (!i_rstn)
    edit_reg[CRIP_PERMIT_BIT] && !storing_reg |=> o_buf_exclude == onehot($past(edit_reg[3:0])))
    else $error("selected buffer not excluded");
  AST_STORE_FIRST: assert property (@(posedge i_clk) disable iff (!i_rstn)
    storing_reg && store_idx_reg == edit_reg[3:0] |=> o_buf_exclude == '0)
    else $error("exclusion applied during store");
  AST_FRESH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rx.store_start |=> fresh_reg[$past(i_rx.idx)])
    else $error("fresh flag not set");
  AST_IDW: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rx.store_done && i_rx.masked |=> o_id_write)
    else $error("identifier write missing");
  AST_TX0: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(txp_reg[0]) |-> irq_reg[CRIP_IRQ_TX0] ##1 o_irq_flags[CRIP_IRQ_TX0])
    else $error("tx0 flag missing");
  AST_TXP_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    txp_reg[1] && !i_tx_done[1] && !i_tx_aborted[1] |=> txp_reg[1])
    else $error("pending cleared without cause");
  AST_RX: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(irq_reg[CRIP_IRQ_RX]) |-> $past(i_rx.store_done && allow_reg[i_rx.idx]))
    else $error("rx flag without cause");
  AST_WAKE_MUTE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wake_reg && !wake_set && !irq_reg[CRIP_IRQ_ERR] && !wsel(CRIP_ESTAT_OFS)
    |=> !irq_reg[CRIP_IRQ_ERR])
    else $error("error flag while wake set");
  AST_STOP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    lp_reg == CRIP_LP_STOP && ctrl_reg[CRIP_LP_BIT] |=> lp_reg == CRIP_LP_STOP)
    else $error("stop left without software");
  AST_INIT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctrl_reg[CRIP_INIT_BIT] |=> !edit_reg[CRIP_PERMIT_BIT])
    else $error("permit survived init");
endmodule : crip_ctl

/* dv/crip_engine_model.sv */
// Bit-engine and bus-side stand-in for crip_ctl: frame stores, transmit results, levels, wake.
// Assumes the bench calls its tasks and sets its level outputs right after rising edges.
module crip_engine_model
  import crip_pkg::*;
(
  // Clock
  input  wire logic   i_clk,
  // Towards the controller
  output crip_rx_t    o_rx,
  output crip_lvl_t   o_lvl,
  output logic        o_ovr,
  output logic [1:0]  o_tx_done,
  output logic [1:0]  o_tx_aborted,
  output logic        o_clk_resume,
  output logic        o_bus_busy,
  output logic        o_bus_wake
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {o_rx, o_lvl, o_ovr, o_tx_done, o_tx_aborted, o_clk_resume, o_bus_busy, o_bus_wake} = '0;
  end

  // Fields flip after the store so stale values never look like a valid frame
  task automatic frame(input logic [3:0] idx, input logic ok, hit, msk, input int gap);
    @(posedge i_clk);
    o_rx <= '{frame_valid: ~ok, hit: ~hit, masked: msk, store_start: 1'b1, store_done: 1'b0, idx: idx};
    @(posedge i_clk);
    o_rx.store_start <= 1'b0;
    repeat (gap) @(posedge i_clk);
    o_rx <= '{frame_valid: ok, hit: hit, masked: msk, store_start: 1'b0, store_done: 1'b1, idx: idx};
    @(posedge i_clk);
    o_rx <= '{frame_valid: ~ok, hit: ~hit, masked: ~msk, store_start: 1'b0, store_done: 1'b0, idx: ~idx};
  endtask : frame

  // Only these engine pulses may end a pending transmit
  task automatic tx_result(input logic [1:0] done, abrt);
    @(posedge i_clk);
    o_tx_done    <= done;
    o_tx_aborted <= abrt;
    @(posedge i_clk);
    o_tx_done    <= 2'b00;
    o_tx_aborted <= 2'b00;
  endtask : tx_result

  // Clock return or bus activity, one cycle each
  task automatic pulse(input logic resume);
    @(posedge i_clk);
    o_clk_resume <= resume;
    o_bus_wake   <= ~resume;
    @(posedge i_clk);
    o_clk_resume <= 1'b0;
    o_bus_wake   <= 1'b0;
  endtask : pulse
endmodule : crip_engine_model

/* dv/crip_ctl_test.sv */
// Self-checking bench for crip_ctl: register table, edit lock, interrupt flags, low power.
// Assumes crip_engine_model plays the bit engine and this bench is the only APB master.
module crip_ctl_test
  import crip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} crip_row_t;
  localparam crip_row_t ROWS [10] = '{
    '{1'b0, CRIP_EDIT_OFS, 32'h0, 32'h0, 1'b0}, '{1'b0, CRIP_CTRL_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b0, CRIP_ESTAT_OFS, 32'h0, 32'h0, 1'b0}, '{1'b0, CRIP_FRESH_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h1c, 32'hffffffff, 32'h0, 1'b1},
    '{1'b1, CRIP_TX_OFS, 32'h30, 32'h0, 1'b0}, '{1'b0, CRIP_TX_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b1, CRIP_ALLOW_OFS, 32'hffffffff, 32'h0, 1'b0}, '{1'b0, CRIP_ALLOW_OFS, 32'h0, 32'hffff, 1'b0}};

  logic        i_clk   = 1'b0;
  logic        i_rstn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = '0;
  logic [31:0] pwdata  = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, id_write, resync, init, ovr, resume, busy, bwake;
  logic [15:0] excl;
  logic [1:0]  tx_pend, tx_can_control_reg, txd, txa;
  logic [3:0]  flags;
  crip_lp_t    lp;
  crip_rx_t    rx;
  crip_lvl_t   lvl;
  int          bad_count = 0;
  int          compares  = 0;
  int          cycles    = 0;
  logic        id_seen     = 1'b0;
  logic        resync_seen = 1'b0;

  always #20 i_clk = ~i_clk;

  crip_ctl #(.NBUF(16)) i_crip_ctl (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_rx(rx), .i_lvl(lvl), .i_ovr(ovr), .i_tx_done(txd), .i_tx_aborted(txa), .i_clk_resume(resume),
    .i_bus_busy(busy), .i_bus_wake(bwake), .o_buf_exclude(excl), .o_id_write(id_write),
    .o_tx_pending(tx_pend), .o_tx_cancel_req(tx_can_control_reg), .o_init(init), .o_resync(resync),
    .o_lp_state(lp), .o_irq_flags(flags));

  crip_engine_model i_crip_engine_model (
    .i_clk(i_clk), .o_rx(rx), .o_lvl(lvl), .o_ovr(ovr), .o_tx_done(txd), .o_tx_aborted(txa),
    .o_clk_resume(resume), .o_bus_busy(busy), .o_bus_wake(bwake));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  // Request held until pready is seen high; the global timeout bounds the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge i_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask : rd

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (id_write === 1'b1) id_seen <= 1'b1;
    if (resync === 1'b1) resync_seen <= 1'b1;
    if (cycles == 4000) begin
      bad_count++;
      test_done();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] q;
    logic        e;
    tick(8);
    i_rstn <= 1'b1;
    foreach (ROWS[k]) begin
      apb(ROWS[k].wr, ROWS[k].a, ROWS[k].d, q, e);
      check({31'h0, e}, {31'h0, ROWS[k].e});
      if (!ROWS[k].wr) check(q, ROWS[k].q);
    end
    for (int k = 0; k < 16; k += 15) begin
      rd(CRIP_FRESH_OFS, 32'h0);
      wr(CRIP_EDIT_OFS, 32'(k));
      wr(CRIP_EDIT_OFS, 32'(k) | 32'h80);
      tick(2);
      check({16'h0, excl}, 32'h1 << k);
      wr(CRIP_EDIT_OFS, 32'(k));
      tick(2);
      check({16'h0, excl}, 32'h0);
    end
    // Permit raised while buffer 3 is mid-store: exclusion must wait
    wr(CRIP_EDIT_OFS, 32'h3);
    fork
      i_crip_engine_model.frame(4'h3, 1'b1, 1'b1, 1'b1, 12);
      begin
        tick(1);
        wr(CRIP_EDIT_OFS, 32'h83);
        tick(2);
        check({16'h0, excl}, 32'h0);
      end
    join
    tick(3);
    check({16'h0, excl}, 32'h8);
    check({31'h0, id_seen}, 32'h1);
    check({28'h0, flags}, 32'h2);
    rd(CRIP_FRESH_OFS, 32'h8);
    wr(CRIP_IRQ_OFS, 32'h2);
    tick(2);
    check({28'h0, flags}, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(CRIP_ALLOW_OFS, (k == 2) ? 32'h0 : 32'hffff);
      i_crip_engine_model.frame(4'h1, k != 0, k != 1, 1'b0, 1);
      tick(3);
      check({28'h0, flags}, 32'h0);
    end
    wr(CRIP_CTRL_OFS, 32'h1);
    tick(2);
    check({31'h0, init}, 32'h1);
    rd(CRIP_EDIT_OFS, 32'h3);
    wr(CRIP_CTRL_OFS, 32'h0);
    // Transmit: software cannot clear, abort needs a cancel request
    wr(CRIP_TX_OFS, 32'h3);
    wr(CRIP_TX_OFS, 32'h0);
    i_crip_engine_model.tx_result(2'b00, 2'b11);
    tick(3);
    check({30'h0, tx_pend}, 32'h3);
    wr(CRIP_TX_OFS, 32'h10);
    tick(2);
    check({30'h0, tx_can_control_reg}, 32'h1);
    i_crip_engine_model.tx_result(2'b00, 2'b01);
    tick(3);
    check({26'h0, tx_pend, flags}, 32'h24);
    i_crip_engine_model.tx_result(2'b10, 2'b00);
    tick(3);
    check({26'h0, tx_pend, flags}, 32'h0c);
    wr(CRIP_IRQ_OFS, 32'hc);
    for (int k = 0; k < 3; k++) begin
      i_crip_engine_model.o_lvl <= i_crip_engine_model.o_lvl ^ crip_lvl_t'(3'h1 << k);
      tick(3);
      check({28'h0, flags}, 32'h1);
      wr(CRIP_IRQ_OFS, 32'h1);
    end
    i_crip_engine_model.o_ovr <= 1'b1;
    tick(3);
    check({28'h0, flags}, 32'h1);
    rd(CRIP_ESTAT_OFS, 32'h72);
    wr(CRIP_ESTAT_OFS, 32'h2);
    i_crip_engine_model.pulse(1'b1);
    tick(3);
    rd(CRIP_ESTAT_OFS, 32'h72);
    wr(CRIP_ESTAT_OFS, 32'h2);
    // Sleep refused on a busy bus, then wake blocks error events
    i_crip_engine_model.o_bus_busy <= 1'b1;
    wr(CRIP_CTRL_OFS, 32'h2);
    tick(3);
    check(32'(lp), 32'(CRIP_LP_RUN));
    rd(CRIP_ESTAT_OFS, 32'h71);
    rd(CRIP_CTRL_OFS, 32'h0);
    wr(CRIP_IRQ_OFS, 32'h1);
    i_crip_engine_model.o_lvl <= '0;
    tick(3);
    check({28'h0, flags}, 32'h0);
    wr(CRIP_ESTAT_OFS, 32'h1);
    i_crip_engine_model.o_bus_busy <= 1'b0;
    wr(CRIP_CTRL_OFS, 32'h2);
    tick(3);
    check(32'(lp), 32'(CRIP_LP_SLEEP));
    rd(CRIP_ESTAT_OFS, 32'h5);
    wr(CRIP_ESTAT_OFS, 32'h1);
    i_crip_engine_model.pulse(1'b0);
    tick(3);
    check(32'(lp), 32'(CRIP_LP_RUN));
    check({31'h0, resync_seen}, 32'h1);
    wr(CRIP_ESTAT_OFS, 32'h1);
    wr(CRIP_CTRL_OFS, 32'h6);
    tick(3);
    check(32'(lp), 32'(CRIP_LP_STOP));
    i_crip_engine_model.pulse(1'b0);
    tick(3);
    check(32'(lp), 32'(CRIP_LP_STOP));
    wr(CRIP_CTRL_OFS, 32'h0);
    tick(3);
    check(32'(lp), 32'(CRIP_LP_RUN));
    // Reset in mid-run with permit and a pending transmit held
    wr(CRIP_EDIT_OFS, 32'h9);
    wr(CRIP_EDIT_OFS, 32'h89);
    wr(CRIP_TX_OFS, 32'h1);
    i_rstn <= 1'b0;
    tick(2);
    check({5'h0, init, id_write, resync, excl, tx_pend, flags, lp}, 32'h0);
    i_rstn <= 1'b1;
    rd(CRIP_EDIT_OFS, 32'h0);
    rd(CRIP_TX_OFS, 32'h0);
    // Overrun level still high across release must not look like a new event
    rd(CRIP_ESTAT_OFS, 32'h0);
    check({28'h0, flags}, 32'h0);
    test_done();
  end
endmodule : crip_ctl_test
